/* rtl/aicr_pkg.sv */
// register map, field positions and shared types for the interface config bank
package aicr_pkg;
    localparam logic [7:0] AICR_OFS_SCRATCH = 8'h0a;
    localparam logic [7:0] AICR_OFS_IF_CFG_A = 8'h01;
    localparam logic [7:0] AICR_OFS_PROTO_REV = 8'h0b;
    localparam logic [7:0] AICR_OFS_MAKER_LO = 8'h0c;
    localparam logic [7:0] AICR_OFS_MAKER_HI = 8'h0d;
    localparam logic [7:0] AICR_OFS_STREAM_DEPTH = 8'h0e;
    localparam logic [7:0] AICR_OFS_APPLY = 8'h0f;
    localparam logic [7:0] AICR_OFS_DEV_OPTIONS = 8'h10;
    localparam logic [7:0] AICR_OFS_PACKET_SETUP = 8'h11;
    localparam int AICR_BIT_APPLY = 0;
    localparam int AICR_BIT_STAGED_READ = 5;
    localparam int AICR_BIT_XCLK_EN = 0;
    localparam int AICR_BIT_GAIN_FIX = 1;
    localparam int AICR_BIT_SDO_SRC = 2;
    localparam int AICR_BIT_AA_SEL = 3;
    localparam int AICR_BIT_SEED_POLICY = 7;
    localparam logic [7:0] AICR_DEV_OPT_MASK = 8'h0f;
    localparam logic [7:0] AICR_IF_CFG_A_MASK = 8'h20;
    localparam logic [7:0] AICR_RST_STREAM_DEPTH = 8'h00;
    localparam logic [7:0] AICR_RST_APPLY = 8'h00;
    localparam logic [7:0] AICR_RST_DEV_OPTIONS = 8'h00;
    localparam logic [7:0] AICR_RST_PACKET_SETUP = 8'h00;
    localparam logic [7:0] AICR_RST_IF_CFG_A = 8'h00;
    // arbitrary neutral identity values
    localparam logic [7:0] AICR_PROTO_REV_VAL = 8'h11;
    localparam logic [7:0] AICR_MAKER_LO_VAL = 8'ha5;
    localparam logic [7:0] AICR_MAKER_HI_VAL = 8'h5a;
    localparam int AICR_CLK_MHZ = 100;
    localparam int AICR_BITCLK_BASE_MHZ = 48;
    localparam int AICR_DIV_W = 16;
    localparam logic [1:0] AICR_FRAME_16 = 2'h0;
    localparam logic [1:0] AICR_FRAME_16_CRC = 2'h1;
    localparam logic [1:0] AICR_FRAME_24 = 2'h2;
    localparam logic [1:0] AICR_FRAME_24_CRC = 2'h3;
    localparam logic [5:0] AICR_CRC_SEED = 6'h00;
    localparam logic [4:0] AICR_LEN_16 = 5'd16;
    localparam logic [4:0] AICR_LEN_24 = 5'd24;
    localparam logic [4:0] AICR_LEN_CRC = 5'd6;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } aicr_req_s;

    typedef struct packed {
        logic seedPolicy;
        logic [1:0] frameFormat;
        logic [3:0] bitClockRate;
        logic antialiasSelect;
        logic serialOutSource;
        logic gainFixEnable;
        logic clockOutEnable;
    } aicr_active_s;

    typedef enum logic [1:0] {
        AICR_IDLE = 2'b01,
        AICR_COPY = 2'b10
    } aicr_state_e;
endpackage : aicr_pkg

/* rtl/aicr_config_regs.sv */
// staged/active configuration register bank with output framing controls
//
// Overview of operation
// - setting apply copies staged values to active, then the bit clears itself.
// - staged registers read back active values unless staged readback bit is set.
// - a low-to-high change of the apply bit also starts the copy.
// - eight-bit read/write stream loop depth register.
// - shared pin carries register data at 0, conversion lane zero at 1.
// - reference gain correction runs only while its enable is one.
// - crystal clock output driven only while its enable is one.
// - upper four bits of device options always read zero.
// - seed policy 0 reloads the checksum seed at each frame end.
// - seed policy 1 carries the checksum across frames.
// - frame format picks 16 or 24 data bits, optionally plus 6 checksum bits.
// - bit clock is near 48 MHz over two to the power of the rate code for codes 0 to 11; code 15 stops it.
// - read-only protocol revision register.
`timescale 1ns/1ps
`default_nettype none
module aicr_config_regs (
    input wire logic clk,
    input wire logic rst,
    input wire aicr_pkg::aicr_req_s req,
    output logic [7:0] rdata,
    output logic rvalid,
    input wire logic regReadBit,
    input wire logic laneZeroBit,
    input wire logic crystalClock,
    input wire logic frameEnd,
    input wire logic [5:0] crcNext,
    output logic sharedOutputPin,
    output logic crystalClockOutput,
    output logic gainFixActive,
    output logic antialiasMode,
    output logic dataBitClock,
    output logic [4:0] frameBits,
    output logic [5:0] crcSeed,
    output var aicr_pkg::aicr_active_s activeCfg
);
    import aicr_pkg::*;

    // pin-side inputs are synchronised before use
    logic [1:0] laneSync_r;
    logic [1:0] xclkSync_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            laneSync_r <= 2'h0;
            xclkSync_r <= 2'h0;
        end else begin
            laneSync_r <= {laneSync_r[0], laneZeroBit};
            xclkSync_r <= {xclkSync_r[0], crystalClock};
        end
    end

    // staged copies written by the host
    logic [7:0] stream_r, stream_nxt;
    logic [7:0] devOpt_r, devOpt_nxt;
    logic [7:0] packet_r, packet_nxt;
    logic [7:0] ifCfgA_r, ifCfgA_nxt;
    logic [7:0] scratch_r, scratch_nxt;
    logic applyBit_r, applyBit_nxt;
    aicr_state_e state_r, state_nxt;
    aicr_active_s active_r, active_nxt;
    logic [7:0] rdata_nxt;
    logic rvalid_nxt;
    logic applyWrite;
    logic applyRise;

    assign applyWrite = req.wrEn && (req.addr == AICR_OFS_APPLY);
    // only a 0->1 write starts a copy; rewriting 1 while busy is a no-op
    assign applyRise = applyWrite && req.wdata[AICR_BIT_APPLY] && !applyBit_r;

    always_comb begin
        stream_nxt = stream_r;
        devOpt_nxt = devOpt_r;
        packet_nxt = packet_r;
        ifCfgA_nxt = ifCfgA_r;
        scratch_nxt = scratch_r;
        applyBit_nxt = applyBit_r;
        state_nxt = state_r;
        active_nxt = active_r;
        if (req.wrEn) begin
            unique case (req.addr)
                AICR_OFS_STREAM_DEPTH: stream_nxt = req.wdata;
                AICR_OFS_DEV_OPTIONS: devOpt_nxt = req.wdata & AICR_DEV_OPT_MASK;
                // bit 6 stored as written; host keeps it zero
                AICR_OFS_PACKET_SETUP: packet_nxt = req.wdata;
                AICR_OFS_IF_CFG_A: ifCfgA_nxt = req.wdata & AICR_IF_CFG_A_MASK;
                AICR_OFS_SCRATCH: scratch_nxt = req.wdata;
                default: ;
            endcase
        end
        unique case (state_r)
            AICR_IDLE: begin
                if (applyRise) begin
                    applyBit_nxt = 1'b1;
                    state_nxt = AICR_COPY;
                end
            end
            AICR_COPY: begin
                active_nxt.clockOutEnable = devOpt_r[AICR_BIT_XCLK_EN];
                active_nxt.gainFixEnable = devOpt_r[AICR_BIT_GAIN_FIX];
                active_nxt.serialOutSource = devOpt_r[AICR_BIT_SDO_SRC];
                active_nxt.antialiasSelect = devOpt_r[AICR_BIT_AA_SEL];
                active_nxt.seedPolicy = packet_r[AICR_BIT_SEED_POLICY];
                active_nxt.frameFormat = packet_r[5:4];
                active_nxt.bitClockRate = packet_r[3:0];
                // autoclear tells the host the copy is done
                applyBit_nxt = 1'b0;
                state_nxt = AICR_IDLE;
            end
            default: begin
                state_nxt = AICR_IDLE;
                applyBit_nxt = 1'b0;
            end
        endcase
    end

    function automatic logic [7:0] aicr_pack_opt(input aicr_active_s a);
        aicr_pack_opt = {4'h0, a.antialiasSelect, a.serialOutSource,
                         a.gainFixEnable, a.clockOutEnable};
    endfunction

    function automatic logic [7:0] aicr_pack_pkt(input aicr_active_s a);
        aicr_pack_pkt = {a.seedPolicy, 1'b0, a.frameFormat, a.bitClockRate};
    endfunction

    logic showStaged;
    assign showStaged = ifCfgA_r[AICR_BIT_STAGED_READ];

    always_comb begin
        rvalid_nxt = req.rdEn;
        rdata_nxt = rdata;
        if (req.rdEn) begin
            unique case (req.addr)
                AICR_OFS_IF_CFG_A: rdata_nxt = ifCfgA_r;
                AICR_OFS_SCRATCH: rdata_nxt = scratch_r;
                AICR_OFS_PROTO_REV: rdata_nxt = AICR_PROTO_REV_VAL;
                AICR_OFS_MAKER_LO: rdata_nxt = AICR_MAKER_LO_VAL;
                AICR_OFS_MAKER_HI: rdata_nxt = AICR_MAKER_HI_VAL;
                AICR_OFS_STREAM_DEPTH: rdata_nxt = stream_r;
                AICR_OFS_APPLY: rdata_nxt = {7'h00, applyBit_r};
                AICR_OFS_DEV_OPTIONS: rdata_nxt = showStaged ? devOpt_r
                                                 : aicr_pack_opt(active_r);
                AICR_OFS_PACKET_SETUP: rdata_nxt = showStaged ? packet_r
                                                  : aicr_pack_pkt(active_r);
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stream_r <= AICR_RST_STREAM_DEPTH;
            devOpt_r <= AICR_RST_DEV_OPTIONS;
            packet_r <= AICR_RST_PACKET_SETUP;
            ifCfgA_r <= AICR_RST_IF_CFG_A;
            scratch_r <= 8'h00;
            applyBit_r <= AICR_RST_APPLY[AICR_BIT_APPLY];
            state_r <= AICR_IDLE;
            active_r <= '0;
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            stream_r <= stream_nxt;
            devOpt_r <= devOpt_nxt;
            packet_r <= packet_nxt;
            ifCfgA_r <= ifCfgA_nxt;
            scratch_r <= scratch_nxt;
            applyBit_r <= applyBit_nxt;
            state_r <= state_nxt;
            active_r <= active_nxt;
            rdata <= rdata_nxt;
            rvalid <= rvalid_nxt;
        end
    end

    // bit clock: 48 MHz base approximated by a phase accumulator on 100 MHz
    logic [AICR_DIV_W-1:0] phase_r, phase_nxt;
    logic [AICR_DIV_W:0] phaseSum;
    logic [AICR_DIV_W-1:0] phaseStep;
    // full accumulator span, so the MSB rises once per bit clock period
    assign phaseStep = AICR_DIV_W'(((AICR_BITCLK_BASE_MHZ * (1 << AICR_DIV_W))
                       / AICR_CLK_MHZ) >> active_r.bitClockRate);
    assign phaseSum = {1'b0, phase_r} + {1'b0, phaseStep};
    always_comb begin
        phase_nxt = phaseSum[AICR_DIV_W-1:0];
    end

    // checksum seed and frame length
    logic [5:0] crcSeed_nxt;
    logic [4:0] frameBits_nxt;
    always_comb begin
        crcSeed_nxt = crcSeed;
        if (frameEnd) begin
            crcSeed_nxt = active_r.seedPolicy ? crcNext
                                              : AICR_CRC_SEED;
        end
        unique case (active_r.frameFormat)
            AICR_FRAME_16: frameBits_nxt = AICR_LEN_16;
            AICR_FRAME_16_CRC: frameBits_nxt = AICR_LEN_16 + AICR_LEN_CRC;
            AICR_FRAME_24: frameBits_nxt = AICR_LEN_24;
            AICR_FRAME_24_CRC: frameBits_nxt = AICR_LEN_24 + AICR_LEN_CRC;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase_r <= '0;
            crcSeed <= AICR_CRC_SEED;
            frameBits <= AICR_LEN_16;
            dataBitClock <= 1'b0;
            sharedOutputPin <= 1'b0;
            crystalClockOutput <= 1'b0;
            gainFixActive <= 1'b0;
            antialiasMode <= 1'b0;
            activeCfg <= '0;
        end else begin
            phase_r <= phase_nxt;
            crcSeed <= crcSeed_nxt;
            frameBits <= frameBits_nxt;
            dataBitClock <= phase_r[AICR_DIV_W-1];
            sharedOutputPin <= active_r.serialOutSource ? laneSync_r[1]
                                                        : regReadBit;
            crystalClockOutput <= active_r.clockOutEnable & xclkSync_r[1];
            gainFixActive <= active_r.gainFixEnable;
            antialiasMode <= active_r.antialiasSelect;
            activeCfg <= active_r;
        end
    end

    sequence s_applyStart;
        applyRise && state_r == AICR_IDLE;
    endsequence
    sequence s_copyDone;
        state_r == AICR_COPY ##1 (applyBit_r == 1'b0 && state_r == AICR_IDLE);
    endsequence

    a_apply_autoclear: assert property (@(posedge clk) disable iff (rst)
        s_applyStart |=> s_copyDone)
        else $error("apply bit did not autoclear after copy");
    a_apply_copies: assert property (@(posedge clk) disable iff (rst)
        state_r == AICR_COPY |=> active_r.frameFormat == $past(packet_r[5:4]))
        else $error("active frame format not copied");
    a_rise_starts: assert property (@(posedge clk) disable iff (rst)
        applyRise |=> applyBit_r && state_r == AICR_COPY)
        else $error("rising apply did not start copy");
    a_active_readback: assert property (@(posedge clk) disable iff (rst)
        req.rdEn && req.addr == AICR_OFS_DEV_OPTIONS && !showStaged
        |=> rdata == aicr_pack_opt($past(active_r)))
        else $error("staged value leaked on readback");
    a_opt_upper_zero: assert property (@(posedge clk) disable iff (rst)
        rvalid && $past(req.addr) == AICR_OFS_DEV_OPTIONS |-> rdata[7:4] == 4'h0)
        else $error("device options upper bits not zero");
    a_stream_hold: assert property (@(posedge clk) disable iff (rst)
        req.wrEn && req.addr == AICR_OFS_STREAM_DEPTH |=> stream_r == $past(req.wdata))
        else $error("stream depth not stored");
    a_rev_const: assert property (@(posedge clk) disable iff (rst)
        rvalid && $past(req.addr) == AICR_OFS_PROTO_REV |-> rdata == AICR_PROTO_REV_VAL)
        else $error("protocol revision wrong");
    a_seed_reset: assert property (@(posedge clk) disable iff (rst)
        frameEnd && !active_r.seedPolicy |=> crcSeed == AICR_CRC_SEED)
        else $error("checksum seed not reloaded");
    a_seed_carry: assert property (@(posedge clk) disable iff (rst)
        frameEnd && active_r.seedPolicy |=> crcSeed == $past(crcNext))
        else $error("checksum not carried");
    a_xclk_gate: assert property (@(posedge clk) disable iff (rst)
        !active_r.clockOutEnable |=> !crystalClockOutput)
        else $error("clock output driven while disabled");
    a_gain_gate: assert property (@(posedge clk) disable iff (rst)
        gainFixActive |-> $past(active_r.gainFixEnable))
        else $error("gain fix active while disabled");
    a_pin_source: assert property (@(posedge clk) disable iff (rst)
        !active_r.serialOutSource |=> sharedOutputPin == $past(regReadBit))
        else $error("shared pin not carrying register data");
    a_frame_len: assert property (@(posedge clk) disable iff (rst)
        active_r.frameFormat == AICR_FRAME_24_CRC && $stable(active_r) |=> frameBits == 5'd30)
        else $error("frame length wrong");
endmodule // aicr_config_regs
`default_nettype wire

/* testbench/aicr_host_model.sv */
// host model driving the register request port of the config bank
`timescale 1ns/1ps
`default_nettype none
module aicr_host_model (
    input wire logic clk,
    output var aicr_pkg::aicr_req_s req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    import aicr_pkg::*;
    initial req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a,
            wdata: (a == AICR_OFS_PACKET_SETUP) ? (d & 8'hbf) : d};
        @(negedge clk);
        // released bus shows a changed pattern, not the old request
        req <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(negedge clk);
        req <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        req <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: 8'hff};
        n = 0;
        while (rvalid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        d = (rvalid === 1'b1) ? rdata : 8'hxx;
    endtask
    // settings are trusted only once the apply bit reads back clear
    task automatic applyWait(output int polls);
        logic [7:0] d;
        wr(AICR_OFS_APPLY, 8'h01);
        polls = 0;
        do begin
            rd(AICR_OFS_APPLY, d);
            polls++;
        end while (d[0] !== 1'b0 && polls < 8);
    endtask
endmodule // aicr_host_model
`default_nettype wire

/* testbench/aicr_config_regs_tb.sv */
// self-checking bench for the interface config register bank
`timescale 1ns/1ps
`default_nettype none
module aicr_config_regs_tb;
    import aicr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    aicr_req_s req;
    logic [7:0] rdata;
    logic rvalid, sharedOutputPin, crystalClockOutput, gainFixActive, antialiasMode, dataBitClock;
    logic regReadBit = 1'b0, laneZeroBit = 1'b0, crystalClock = 1'b0, frameEnd = 1'b0;
    logic [5:0] crcNext = 6'h00;
    logic [5:0] crcSeed;
    logic [4:0] frameBits;
    aicr_active_s activeCfg;
    int err_count = 0, num_checks = 0, cyc = 0;
    int stOpt = 0, stPkt = 0, acOpt = 0, acPkt = 0, depth = 0, stRd = 0;
    logic [7:0] rdQ[$] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h01, 8'h30};
    aicr_config_regs dut_u (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
        .regReadBit(regReadBit), .laneZeroBit(laneZeroBit), .crystalClock(crystalClock),
        .frameEnd(frameEnd), .crcNext(crcNext), .sharedOutputPin(sharedOutputPin),
        .crystalClockOutput(crystalClockOutput), .gainFixActive(gainFixActive),
        .antialiasMode(antialiasMode), .dataBitClock(dataBitClock), .frameBits(frameBits),
        .crcSeed(crcSeed), .activeCfg(activeCfg));
    aicr_host_model host_u (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] expRd(input logic [7:0] a);
        case (a)
            AICR_OFS_IF_CFG_A: return 8'(stRd << 5);
            AICR_OFS_PROTO_REV: return AICR_PROTO_REV_VAL;
            AICR_OFS_MAKER_LO: return AICR_MAKER_LO_VAL;
            AICR_OFS_MAKER_HI: return AICR_MAKER_HI_VAL;
            AICR_OFS_STREAM_DEPTH: return 8'(depth);
            AICR_OFS_DEV_OPTIONS: return 8'((stRd ? stOpt : acOpt) & 8'h0f);
            AICR_OFS_PACKET_SETUP: return 8'(stRd ? stPkt : acPkt & 8'hbf);
            default: return 8'h00;
        endcase
    endfunction
    task automatic rdChk(input logic [7:0] a);
        logic [7:0] d;
        host_u.rd(a, d);
        chk(d, expRd(a));
    endtask
    task automatic wrM(input logic [7:0] a, input logic [7:0] d);
        host_u.wr(a, d);
        if (a == AICR_OFS_DEV_OPTIONS) stOpt = d;
        if (a == AICR_OFS_PACKET_SETUP) stPkt = d & 8'hbf;
        if (a == AICR_OFS_STREAM_DEPTH) depth = d;
        if (a == AICR_OFS_IF_CFG_A) stRd = d[5];
    endtask
    task automatic checkOuts();
        chk(gainFixActive, acOpt[1]);
        chk(antialiasMode, acOpt[3]);
        chk(activeCfg.clockOutEnable, acOpt[0]);
        chk(activeCfg.serialOutSource, acOpt[2]);
        chk(activeCfg.frameFormat, acPkt[5:4]);
        chk(frameBits, (acPkt[5] ? 24 : 16) + (acPkt[4] ? 6 : 0));
        chk(activeCfg.bitClockRate, acPkt[3:0]);
        chk(activeCfg.seedPolicy, acPkt[7]);
    endtask
    task automatic apply();
        int p;
        host_u.applyWait(p);
        chk(p < 8, 1);
        acOpt = stOpt;
        acPkt = stPkt;
        repeat (3) @(posedge clk);
        #1;
        checkOuts();
        foreach (rdQ[i]) rdChk(rdQ[i]);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        int n, e;
        logic prev;
        void'($urandom(32'h8cd7));
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        #1;
        checkOuts();
        foreach (rdQ[i]) rdChk(rdQ[i]);
        $display("test reset done");
        wrM(AICR_OFS_STREAM_DEPTH, 8'($urandom));
        rdChk(AICR_OFS_STREAM_DEPTH);
        wrM(AICR_OFS_DEV_OPTIONS, 8'($urandom) | 8'hf0);
        wrM(AICR_OFS_PACKET_SETUP, 8'($urandom) | 8'h40);
        foreach (rdQ[i]) rdChk(rdQ[i]);
        wrM(AICR_OFS_IF_CFG_A, 8'h20);
        foreach (rdQ[i]) rdChk(rdQ[i]);
        wrM(AICR_OFS_IF_CFG_A, 8'h00);
        apply();
        $display("test staging done");
        // odd formats also switch the seed policy, so both policies are seen
        for (int f = 0; f < 4; f++) begin
            wrM(AICR_OFS_PACKET_SETUP, 8'(((f & 1) << 7) | (f << 4) | ($urandom % 16)));
            apply();
            @(negedge clk);
            crcNext = 6'($urandom);
            frameEnd = 1'b1;
            @(negedge clk);
            frameEnd = 1'b0;
            @(posedge clk);
            #1;
            chk(crcSeed, f[0] ? crcNext : AICR_CRC_SEED);
        end
        $display("test framing done");
        for (int i = 0; i < 4; i++) begin
            wrM(AICR_OFS_DEV_OPTIONS, 8'(($urandom & 32'hfa) | (i[1] << 2) | i[0]));
            apply();
            repeat (4) begin
                @(negedge clk);
                regReadBit = 1'($urandom);
                laneZeroBit = 1'($urandom);
                crystalClock = 1'($urandom);
                repeat (4) @(posedge clk);
                #1;
                chk(sharedOutputPin, i[1] ? laneZeroBit : regReadBit);
                chk(crystalClockOutput, i[0] & crystalClock);
            end
        end
        $display("test pins done");
        // accumulator clock is only close on average, hence the tolerance
        for (int c = 0; c < 6; c++) begin
            wrM(AICR_OFS_PACKET_SETUP, 8'(c));
            apply();
            n = 0;
            e = 960 >> c;
            prev = dataBitClock;
            repeat (2000) begin
                @(posedge clk);
                #1;
                if (dataBitClock === 1'b1 && prev === 1'b0) n++;
                prev = dataBitClock;
            end
            chk(n >= e - 2 - e / 64 && n <= e + 2 + e / 64, 1);
        end
        $display("test bit clock done");
        tally_and_finish();
    end
endmodule // aicr_config_regs_tb
`default_nettype wire
